// [verilog/ipc_config_front_end.sv]
//
// Contract
// RQ1: with strap asserted, run auto-config protocol, start in wait-for-key state.
// RQ2: decode write-only index port at 0x279 selecting target register.
// RQ3: decode write-only data port at 0xa79 loading selected register.
// RQ4: read port address programmable from 0x203 to 0x3ff; the code takes any value, giving 0x003 to 0x3ff.
// RQ5: only activated units respond; inactive units drive nothing.
// RQ6: hold resource settings in on-chip rom, readable through read port.
// RQ7: resource data of each unit carries a product identifier.
// RQ8: codec io base at 0x60/0x61, 0x0008..0xfff8, 8-byte aligned window.
// RQ9: codec irq at 0x70 routed only to levels 3,4,5,7,9,10,11,12.
// RQ10: codec uses one or two dma channels set at 0x74 and 0x75.
// RQ11: 16-bit playback with 8-bit capture, or two 8-bit channels, allowed.
// RQ12: single channel is shared; capture and playback cannot run together.
// RQ13: unit number at 0x07 selects unit registers 0x30..0xff; lower stay global.
// RQ14: capture channel disabled means capture also runs on playback channel.
// RQ15: registers reset at power-up; no unit decodes until activated.
module ipc_config_front_end (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic autoconfig_mode_strap,
    input wire ipc_pkg::ipc_isa_t isa_in,
    output logic [7:0] sd_out,
    output logic sd_oe_n,
    output logic codec_sel,
    input wire logic codec_irq,
    input wire logic codec_play_drq,
    input wire logic codec_cap_drq,
    output logic codec_play_dack,
    output logic codec_cap_dack,
    output logic codec_shared_dma,
    output logic [15:0] isa_irq,
    output logic [7:0] isa_drq
);
    import ipc_pkg::*;

    ipc_isa_t isa_s1_r, isa_s2_r;
    logic strap_s1_r, strap_s2_r;
    logic iow_prev_r, ior_prev_r, hold_aen_r, rd_hit_prev_r;
    logic [15:0] hold_sa_r;
    logic [7:0] hold_sd_r;
    ipc_state_t state_r;
    logic [7:0] idx_r, rdp_r, csn_r, unit_r, res_ptr_r;
    logic [NUM_UNITS-1:0] act_r;
    ipc_codec_cfg_t cdc_r;
    logic [7:0] sd_out_r;
    logic sd_oe_n_r, codec_sel_r, play_dack_r, cap_dack_r, shared_r;
    logic [15:0] isa_irq_r;
    logic [7:0] isa_drq_r;

    logic wr_end, rd_end, wr_idx, wr_dat, cfg_wr, iso_wr, wr_ctl, wr_wake, key_ok, rd_hit;
    logic unit_sel_ok, codec_unit;
    logic [15:0] rdp_addr, io_base;
    logic [7:0] rd_data, rom_data;
    logic base_ok, irq_ok, play_ok, cap_ok, cap_en, codec_act;

    // two-stage synchronisers for isa bus pins and strap
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            isa_s1_r <= ISA_IDLE;
            isa_s2_r <= ISA_IDLE;
            // strap taken as high until seen, so reset cannot skip wait-for-key
            strap_s1_r <= 1'b1; // see RQ1
            strap_s2_r <= 1'b1; // see RQ1
        end else begin
            isa_s1_r <= isa_in;
            isa_s2_r <= isa_s1_r;
            strap_s1_r <= autoconfig_mode_strap;
            strap_s2_r <= strap_s1_r;
        end
    end

    // write address and data held while the strobe is low, used at its trailing edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            iow_prev_r <= 1'b1;
            ior_prev_r <= 1'b1;
            hold_sa_r <= 16'h0000;
            hold_sd_r <= 8'h00;
            hold_aen_r <= 1'b1;
            rd_hit_prev_r <= 1'b0;
        end else begin
            iow_prev_r <= isa_s2_r.iow_n;
            ior_prev_r <= isa_s2_r.ior_n;
            rd_hit_prev_r <= rd_hit;
            if (!isa_s2_r.iow_n) begin
                hold_sa_r <= isa_s2_r.sa;
                hold_sd_r <= isa_s2_r.sd;
                hold_aen_r <= isa_s2_r.aen;
            end
        end
    end

    assign wr_end = isa_s2_r.iow_n && !iow_prev_r && !hold_aen_r;
    assign rd_end = isa_s2_r.ior_n && !ior_prev_r;
    assign wr_idx = wr_end && hold_sa_r == IDX_PORT_ADDR; // see RQ2
    assign wr_dat = wr_end && hold_sa_r == WDATA_PORT_ADDR; // see RQ3
    assign cfg_wr = wr_dat && state_r == ST_CONFIG;
    assign iso_wr = wr_dat && state_r == ST_ISOLATE;
    assign wr_ctl = (cfg_wr || iso_wr) && idx_r == IX_CFG_CTL;
    assign wr_wake = wr_dat && idx_r == IX_WAKE && state_r != ST_WAIT_KEY;
    assign unit_sel_ok = unit_r < NUM_UNITS;
    assign codec_unit = unit_r == CODEC_UNIT;

    ipc_key_detect u_key (
        .ref_clk(ref_clk),
        .rst(rst),
        .armed(state_r == ST_WAIT_KEY && strap_s2_r),
        .wr_pulse(wr_idx),
        .wr_data(hold_sd_r),
        .key_ok(key_ok)
    );

    // protocol states; strap low keeps every unit in config
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_WAIT_KEY; // see RQ15
        end else if (!strap_s2_r) begin
            state_r <= ST_CONFIG;
        end else begin
            case (state_r)
                ST_WAIT_KEY: begin
                    if (key_ok) begin
                        state_r <= ST_SLEEP; // see RQ1
                    end
                end
                ST_SLEEP: begin
                    if (wr_wake && hold_sd_r == csn_r) begin
                        state_r <= (hold_sd_r == 8'h00) ? ST_ISOLATE : ST_CONFIG;
                    end
                end
                ST_ISOLATE, ST_CONFIG: begin
                    if (wr_ctl && hold_sd_r[CTL_WAIT_KEY_BIT]) begin
                        state_r <= ST_WAIT_KEY; // see RQ1
                    end else if (wr_wake) begin
                        state_r <= (hold_sd_r != csn_r) ? ST_SLEEP :
                                   (hold_sd_r == 8'h00) ? ST_ISOLATE : ST_CONFIG;
                    end else if (iso_wr && idx_r == IX_CSN) begin
                        state_r <= ST_CONFIG;
                    end
                end
                default: begin
                    state_r <= ST_WAIT_KEY;
                end
            endcase
        end
    end

    // index and global registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            idx_r <= 8'h00;
            rdp_r <= RDP_RESET;
            csn_r <= CSN_RESET;
            unit_r <= UNIT_RESET;
        end else begin
            if (wr_idx) begin
                idx_r <= hold_sd_r; // see RQ2
            end
            if ((cfg_wr || iso_wr) && idx_r == IX_RD_PORT) begin
                rdp_r <= hold_sd_r; // see RQ4
            end
            if (wr_ctl && hold_sd_r[CTL_CSN_RESET_BIT]) begin
                csn_r <= CSN_RESET;
            end else if ((cfg_wr || iso_wr) && idx_r == IX_CSN) begin
                csn_r <= hold_sd_r;
            end
            if (cfg_wr && idx_r == IX_UNIT) begin
                unit_r <= hold_sd_r; // see RQ13
            end
        end
    end

    // per-unit registers, reached through the unit number
    always_ff @(posedge ref_clk) begin
        if (rst || (wr_ctl && hold_sd_r[CTL_RESET_BIT])) begin
            act_r <= '0; // see RQ15
            cdc_r <= CODEC_RESET;
        end else if (cfg_wr && idx_r >= IX_UNIT_BASE && unit_sel_ok) begin // see RQ13
            if (idx_r == IX_ACTIVATE) begin
                act_r[unit_r[2:0]] <= hold_sd_r[0];
            end
            if (codec_unit) begin
                case (idx_r)
                    IX_IO_HI: cdc_r.io_hi <= hold_sd_r; // see RQ8
                    IX_IO_LO: cdc_r.io_lo <= hold_sd_r; // see RQ8
                    IX_IRQ: cdc_r.irq <= hold_sd_r; // see RQ9
                    IX_DMA_CAP: cdc_r.dma_cap <= hold_sd_r; // see RQ10
                    IX_DMA_PLAY: cdc_r.dma_play <= hold_sd_r; // see RQ10
                    default: begin
                    end
                endcase
            end
        end
    end

    // resource pointer restarts on wake, steps after each resource byte read and holds at 0xff
    always_ff @(posedge ref_clk) begin
        if (rst || wr_wake) begin
            res_ptr_r <= 8'h00;
        end else if (rd_end && rd_hit_prev_r && idx_r == IX_RES_DATA && res_ptr_r != 8'hff) begin
            res_ptr_r <= res_ptr_r + 8'h01; // see RQ6
        end
    end

    ipc_res_rom u_rom (
        .unit(unit_r[2:0]),
        .ptr(res_ptr_r),
        .data(rom_data)
    );

    assign rdp_addr = {6'h00, rdp_r, 2'b11}; // see RQ4
    assign rd_hit = !isa_s2_r.ior_n && !isa_s2_r.aen && isa_s2_r.sa == rdp_addr &&
                    (state_r == ST_CONFIG || state_r == ST_ISOLATE);

    always_comb begin
        rd_data = 8'h00;
        if (idx_r >= IX_UNIT_BASE && !(unit_sel_ok && (codec_unit || idx_r == IX_ACTIVATE))) begin
            rd_data = 8'h00;
        end else begin
            case (idx_r)
                IX_RD_PORT: rd_data = rdp_r;
                IX_RES_DATA: rd_data = unit_sel_ok ? rom_data : 8'h00; // see RQ6
                IX_STATUS: rd_data = STATUS_READY;
                IX_CSN: rd_data = csn_r;
                IX_UNIT: rd_data = unit_r;
                IX_ACTIVATE: rd_data = {7'h00, act_r[unit_r[2:0]]};
                IX_IO_HI: rd_data = cdc_r.io_hi;
                IX_IO_LO: rd_data = cdc_r.io_lo;
                IX_IRQ: rd_data = cdc_r.irq;
                IX_DMA_CAP: rd_data = cdc_r.dma_cap;
                IX_DMA_PLAY: rd_data = cdc_r.dma_play;
                default: rd_data = 8'h00;
            endcase
        end
    end

    // codec resource checks
    assign codec_act = act_r[0];
    assign io_base = {cdc_r.io_hi, cdc_r.io_lo[7:IO_WIN_BITS], 3'b000};
    assign base_ok = io_base >= IO_BASE_MIN && io_base <= IO_BASE_MAX; // see RQ8
    assign irq_ok = cdc_r.irq[7:4] == 4'h0 && IRQ_ALLOWED[cdc_r.irq[3:0]]; // see RQ9
    assign play_ok = cdc_r.dma_play[7:3] == 5'h00 && DMA_ALLOWED[cdc_r.dma_play[2:0]]; // see RQ10
    assign cap_ok = cdc_r.dma_cap[7:3] == 5'h00 && DMA_ALLOWED[cdc_r.dma_cap[2:0]];
    // wide capture with narrow playback is not a legal pairing
    assign cap_en = cap_ok && play_ok && !(cdc_r.dma_play < DMA_WIDE_MIN && cdc_r.dma_cap >= DMA_WIDE_MIN); // see RQ11

    // bus-facing outputs; nothing decodes or drives for an inactive unit
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sd_out_r <= 8'h00;
            sd_oe_n_r <= 1'b1;
            codec_sel_r <= 1'b0;
            isa_irq_r <= 16'h0000;
            isa_drq_r <= 8'h00;
            play_dack_r <= 1'b0;
            cap_dack_r <= 1'b0;
            shared_r <= 1'b0;
        end else begin
            sd_out_r <= rd_hit ? rd_data : 8'h00;
            sd_oe_n_r <= !rd_hit; // see RQ4
            codec_sel_r <= codec_act && base_ok && !isa_s2_r.aen &&
                           isa_s2_r.sa[15:IO_WIN_BITS] == io_base[15:IO_WIN_BITS] &&
                           (!isa_s2_r.ior_n || !isa_s2_r.iow_n); // see RQ5
            isa_irq_r <= (codec_act && irq_ok && codec_irq) ? (16'h0001 << cdc_r.irq[3:0]) : 16'h0000; // see RQ9
            isa_drq_r <= ((codec_act && play_ok && (codec_play_drq || (!cap_en && codec_cap_drq))) ?
                          (8'h01 << cdc_r.dma_play[2:0]) : 8'h00) |
                         ((codec_act && cap_en && codec_cap_drq) ?
                          (8'h01 << cdc_r.dma_cap[2:0]) : 8'h00); // see RQ14
            play_dack_r <= codec_act && play_ok && !isa_s2_r.dack_n[cdc_r.dma_play[2:0]];
            cap_dack_r <= codec_act && (cap_en ? !isa_s2_r.dack_n[cdc_r.dma_cap[2:0]] :
                          play_ok && !isa_s2_r.dack_n[cdc_r.dma_play[2:0]]); // see RQ14
            shared_r <= codec_act && play_ok && !cap_en; // see RQ12
        end
    end

    assign sd_out = sd_out_r;
    assign sd_oe_n = sd_oe_n_r;
    assign codec_sel = codec_sel_r;
    assign isa_irq = isa_irq_r;
    assign isa_drq = isa_drq_r;
    assign codec_play_dack = play_dack_r;
    assign codec_cap_dack = cap_dack_r;
    assign codec_shared_dma = shared_r;

    sequence s_rd_strobe;
        rd_hit;
    endsequence

    property p_key_wakes;
        @(posedge ref_clk) disable iff (rst) (state_r == ST_WAIT_KEY && key_ok && strap_s2_r) |=> state_r == ST_SLEEP;
    endproperty
    a_key_wakes: assert property (p_key_wakes) else $error("key did not leave wait-for-key"); // see RQ1

    property p_index_load;
        @(posedge ref_clk) disable iff (rst) wr_idx |=> idx_r == $past(hold_sd_r);
    endproperty
    a_index_load: assert property (p_index_load) else $error("index port write lost"); // see RQ2

    property p_read_drive;
        @(posedge ref_clk) disable iff (rst) s_rd_strobe |=> !sd_oe_n && sd_out == $past(rd_data);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read port not driven"); // see RQ4

    property p_no_drive_idle;
        @(posedge ref_clk) disable iff (rst) (state_r == ST_WAIT_KEY || state_r == ST_SLEEP) ##1 1'b1 |-> sd_oe_n;
    endproperty
    a_no_drive_idle: assert property (p_no_drive_idle) else $error("read port driven outside config"); // see RQ5

    property p_inactive_quiet;
        @(posedge ref_clk) disable iff (rst) !codec_act [*2] |-> !codec_sel && isa_irq == 16'h0000 && isa_drq == 8'h00;
    endproperty
    a_inactive_quiet: assert property (p_inactive_quiet) else $error("inactive codec touched the bus"); // see RQ15

    property p_irq_legal;
        @(posedge ref_clk) disable iff (rst) isa_irq != 16'h0000 |-> (isa_irq & ~IRQ_ALLOWED) == 16'h0000;
    endproperty
    a_irq_legal: assert property (p_irq_legal) else $error("irq on an unlisted level"); // see RQ9

    property p_shared_route;
        @(posedge ref_clk) disable iff (rst) (codec_act && play_ok && !cap_en && codec_cap_drq) |=>
            isa_drq[$past(cdc_r.dma_play[2:0])] && codec_shared_dma;
    endproperty
    a_shared_route: assert property (p_shared_route) else $error("capture not carried on playback channel"); // see RQ14

    property p_unit_gate;
        @(posedge ref_clk) disable iff (rst) (cfg_wr && idx_r == IX_IRQ && !codec_unit) |=> $stable(cdc_r.irq);
    endproperty
    a_unit_gate: assert property (p_unit_gate) else $error("codec register hit with another unit selected"); // see RQ13
endmodule

// [verilog/ipc_pkg.sv]
package ipc_pkg;

    // isa port addresses
    localparam logic [15:0] IDX_PORT_ADDR = 16'h0279;
    localparam logic [15:0] WDATA_PORT_ADDR = 16'h0a79;

    // configuration register indices
    localparam logic [7:0] IX_RD_PORT = 8'h00;
    localparam logic [7:0] IX_CFG_CTL = 8'h02;
    localparam logic [7:0] IX_WAKE = 8'h03;
    localparam logic [7:0] IX_RES_DATA = 8'h04;
    localparam logic [7:0] IX_STATUS = 8'h05;
    localparam logic [7:0] IX_CSN = 8'h06;
    localparam logic [7:0] IX_UNIT = 8'h07;
    localparam logic [7:0] IX_UNIT_BASE = 8'h30;
    localparam logic [7:0] IX_ACTIVATE = 8'h30;
    localparam logic [7:0] IX_IO_HI = 8'h60;
    localparam logic [7:0] IX_IO_LO = 8'h61;
    localparam logic [7:0] IX_IRQ = 8'h70;
    localparam logic [7:0] IX_DMA_CAP = 8'h74;
    localparam logic [7:0] IX_DMA_PLAY = 8'h75;

    // config control bit positions
    localparam int CTL_RESET_BIT = 0;
    localparam int CTL_WAIT_KEY_BIT = 1;
    localparam int CTL_CSN_RESET_BIT = 2;

    localparam logic [7:0] NUM_UNITS = 8'h05;
    localparam logic [7:0] CODEC_UNIT = 8'h00;

    // initiation key
    localparam logic [7:0] KEY_SEED = 8'h6a;
    localparam logic [5:0] KEY_LEN = 6'h20;

    // codec window and resource limits
    localparam logic [15:0] IO_BASE_MIN = 16'h0008;
    localparam logic [15:0] IO_BASE_MAX = 16'hfff8;
    localparam int IO_WIN_BITS = 3;
    localparam logic [15:0] IRQ_ALLOWED = 16'h1eb8;
    localparam logic [7:0] DMA_ALLOWED = 8'heb;
    localparam logic [7:0] DMA_NONE = 8'h04;
    localparam logic [7:0] DMA_WIDE_MIN = 8'h04;

    // reset values and fixed answers
    localparam logic [7:0] RDP_RESET = 8'h80;
    localparam logic [7:0] CSN_RESET = 8'h00;
    localparam logic [7:0] UNIT_RESET = 8'h00;
    localparam logic [7:0] STATUS_READY = 8'h01;
    localparam logic [7:0] RES_ID_LEN = 8'h04;
    localparam logic [7:0] RES_LEN = 8'h14;
    localparam logic [7:0] RES_END_TAG = 8'h79;

    typedef struct packed {
        logic [15:0] sa;
        logic [7:0] sd;
        logic iow_n;
        logic ior_n;
        logic aen;
        logic [7:0] dack_n;
    } ipc_isa_t;

    localparam ipc_isa_t ISA_IDLE = '{sa: 16'h0000, sd: 8'h00, iow_n: 1'b1, ior_n: 1'b1, aen: 1'b1, dack_n: 8'hff};

    typedef struct packed {
        logic [7:0] io_hi;
        logic [7:0] io_lo;
        logic [7:0] irq;
        logic [7:0] dma_cap;
        logic [7:0] dma_play;
    } ipc_codec_cfg_t;

    localparam ipc_codec_cfg_t CODEC_RESET = '{io_hi: 8'h00, io_lo: 8'h00, irq: 8'h00,
                                              dma_cap: DMA_NONE, dma_play: DMA_NONE};

    typedef enum logic [1:0] {ST_WAIT_KEY, ST_SLEEP, ST_ISOLATE, ST_CONFIG} ipc_state_t;

endpackage

// [verilog/ipc_key_detect.sv]
module ipc_key_detect (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic armed,
    input wire logic wr_pulse,
    input wire logic [7:0] wr_data,
    output logic key_ok
);
    import ipc_pkg::*;

    logic [7:0] lfsr_r;
    logic [7:0] lfsr_nxt;
    logic [5:0] count_r;

    assign lfsr_nxt = {lfsr_r[1] ^ lfsr_r[0], lfsr_r[7:1]};

    // each matching write advances the sequence, any mismatch restarts it
    always_ff @(posedge ref_clk) begin
        if (rst || !armed) begin
            lfsr_r <= KEY_SEED;
            count_r <= 6'h00;
        end else if (wr_pulse) begin
            if (wr_data == lfsr_r && count_r != KEY_LEN) begin
                lfsr_r <= lfsr_nxt;
                count_r <= count_r + 6'h01;
            end else begin
                lfsr_r <= KEY_SEED;
                count_r <= 6'h00;
            end
        end
    end

    assign key_ok = armed && (count_r == KEY_LEN);
endmodule

// [verilog/ipc_res_rom.sv]
module ipc_res_rom #(
    parameter logic [31:0] PRODUCT_ID_BASE = 32'h1357_9bd0 // arbitrary value
) (
    input wire logic [2:0] unit,
    input wire logic [7:0] ptr,
    output logic [7:0] data
);
    import ipc_pkg::*;

    // codec descriptors: io window, irq mask, dma mask, end tag
    localparam logic [7:0] CODEC_DESC [16] = '{
        8'h47, 8'h01, 8'h08, 8'h00, 8'hf8, 8'hff, 8'h08, 8'h08,
        8'h22, 8'hb8, 8'h1e, 8'h2a, 8'heb, 8'h00, RES_END_TAG, 8'h00
    };

    logic [31:0] product_id;
    logic [7:0] desc_ptr;

    assign product_id = {PRODUCT_ID_BASE[31:3], unit};
    assign desc_ptr = ptr - RES_ID_LEN;

    always_comb begin
        data = 8'h00;
        if (ptr < RES_ID_LEN) begin
            data = product_id[8 * ptr[1:0] +: 8]; // see RQ7
        end else if ({5'h00, unit} == CODEC_UNIT && ptr < RES_LEN) begin
            data = CODEC_DESC[desc_ptr[3:0]]; // see RQ6
        end else if (ptr == RES_ID_LEN) begin
            data = RES_END_TAG;
        end
    end
endmodule

// [test/ipc_host_model.sv]
module ipc_host_model (
    input wire logic ref_clk,
    output ipc_pkg::ipc_isa_t isa
);
    timeunit 1ns;
    timeprecision 100ps;
    import ipc_pkg::*;

    initial isa = ISA_IDLE;

    // read strobe driven low just after an edge and held until cyc_end
    task automatic rd_begin(input logic [15:0] a);
        @(posedge ref_clk);
        #1;
        isa.sa = a;
        isa.aen = 1'b0;
        isa.ior_n = 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        isa.sa = a;
        isa.sd = d;
        isa.aen = 1'b0;
        isa.iow_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        cyc_end();
    endtask

    // strobe up first, address and data dropped a cycle later, then idle gap
    task automatic cyc_end();
        @(posedge ref_clk);
        #1;
        isa.iow_n = 1'b1;
        isa.ior_n = 1'b1;
        @(posedge ref_clk);
        #1;
        isa.sa = ~isa.sa;
        isa.sd = ~isa.sd;
        isa.aen = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    task automatic set_dack(input logic [7:0] v);
        @(posedge ref_clk);
        #1;
        isa.dack_n = v;
    endtask
endmodule

// [test/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ipc_pkg::*;

    // arbitrary value, same as the rom default
    localparam logic [31:0] PID = 32'h1357_9bd0;
    logic ref_clk, rst, strap, c_irq, p_drq, c_drq;
    ipc_isa_t isa;
    logic [7:0] sd_out, isa_drq;
    logic [15:0] isa_irq;
    logic sd_oe_n, codec_sel, p_dack, c_dack, shared;
    int n_fail = 0;
    int total_checks = 0;

    ipc_host_model ipc_host_model_inst (.ref_clk(ref_clk), .isa(isa));
    ipc_config_front_end ipc_config_front_end_inst (
        .ref_clk(ref_clk), .rst(rst), .autoconfig_mode_strap(strap), .isa_in(isa), .sd_out(sd_out),
        .sd_oe_n(sd_oe_n), .codec_sel(codec_sel), .codec_irq(c_irq), .codec_play_drq(p_drq),
        .codec_cap_drq(c_drq), .codec_play_dack(p_dack), .codec_cap_dack(c_dack),
        .codec_shared_dma(shared), .isa_irq(isa_irq), .isa_drq(isa_drq));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic idx(input logic [7:0] v);
        ipc_host_model_inst.wr(IDX_PORT_ADDR, v);
    endtask

    task automatic cfg(input logic [7:0] ix, input logic [7:0] d);
        idx(ix);
        ipc_host_model_inst.wr(WDATA_PORT_ADDR, d);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] ed, input logic eoe, input logic esel);
        ipc_host_model_inst.rd_begin(a);
        repeat (4) @(posedge ref_clk);
        #2;
        chk("sd_oe_n", eoe, sd_oe_n);
        if (eoe === 1'b0) chk("sd_out", ed, sd_out);
        chk("codec_sel", esel, codec_sel);
        ipc_host_model_inst.cyc_end();
    endtask

    task automatic inp(input logic i, input logic p, input logic c);
        @(posedge ref_clk);
        #1;
        c_irq = i;
        p_drq = p;
        c_drq = c;
        repeat (2) @(posedge ref_clk);
        #2;
    endtask

    task automatic dma(input logic [7:0] cp, input logic [7:0] pl, input logic [7:0] eb, input logic [7:0] ec,
                       input logic esh);
        cfg(IX_DMA_CAP, cp);
        cfg(IX_DMA_PLAY, pl);
        inp(1'b0, 1'b1, 1'b1);
        chk("isa_drq", eb, isa_drq);
        inp(1'b0, 1'b0, 1'b1);
        chk("isa_drq", ec, isa_drq);
        chk("shared", esh, shared);
    endtask

    task automatic dack(input logic [7:0] v, input logic ep, input logic ec);
        ipc_host_model_inst.set_dack(v);
        repeat (5) @(posedge ref_clk);
        #2;
        chk("play_dack", ep, p_dack);
        chk("cap_dack", ec, c_dack);
        ipc_host_model_inst.set_dack(8'hff);
    endtask

    task automatic t_key();
        logic [7:0] k;
        logic [31:0] id;
        rd(16'h0203, 8'h00, 1'b1, 1'b0);
        k = KEY_SEED;
        for (int i = 0; i < 32; i++) begin
            idx(k);
            k = {k[1] ^ k[0], k[7:1]};
        end
        cfg(IX_WAKE, 8'h00);
        cfg(IX_CSN, 8'h01);
        cfg(IX_WAKE, 8'h01);
        idx(IX_RES_DATA);
        id = {PID[31:3], 3'b000};
        for (int i = 0; i < 4; i++) rd(16'h0203, id[8*i +: 8], 1'b0, 1'b0);
    endtask

    task automatic t_rdport();
        cfg(IX_RD_PORT, 8'hff);
        idx(IX_STATUS);
        rd(16'h03ff, STATUS_READY, 1'b0, 1'b0);
        rd(16'h0203, 8'h00, 1'b1, 1'b0);
        cfg(IX_RD_PORT, 8'h80);
        idx(IX_STATUS);
        rd(16'h0203, STATUS_READY, 1'b0, 1'b0);
    endtask

    task automatic t_codec();
        logic [7:0] lv [9];
        lv = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h02};
        cfg(IX_UNIT, 8'h01);
        cfg(IX_IRQ, 8'h05);
        cfg(IX_ACTIVATE, 8'h01);
        cfg(IX_UNIT, CODEC_UNIT);
        cfg(IX_IO_HI, 8'h05);
        cfg(IX_IO_LO, 8'h30);
        rd(16'h0530, 8'h00, 1'b1, 1'b0);
        cfg(IX_ACTIVATE, 8'h01);
        inp(1'b1, 1'b0, 1'b0);
        chk("isa_irq", 16'h0000, isa_irq);
        rd(16'h0530, 8'h00, 1'b1, 1'b1);
        rd(16'h0537, 8'h00, 1'b1, 1'b1);
        rd(16'h0538, 8'h00, 1'b1, 1'b0);
        rd(16'h052f, 8'h00, 1'b1, 1'b0);
        for (int i = 0; i < 9; i++) begin
            cfg(IX_IRQ, lv[i]);
            inp(1'b1, 1'b0, 1'b0);
            chk("isa_irq", (i < 8) ? (16'h0001 << lv[i]) : 16'h0000, isa_irq);
        end
        cfg(IX_IRQ, 8'h0a);
        idx(IX_IRQ);
        rd(16'h0203, 8'h0a, 1'b0, 1'b0);
    endtask

    task automatic t_dma();
        dma(8'h01, 8'h05, 8'h22, 8'h02, 1'b0);
        dack(8'hfd, 1'b0, 1'b1);
        dack(8'hdf, 1'b1, 1'b0);
        dma(8'h00, 8'h03, 8'h09, 8'h01, 1'b0);
        dma(8'h07, 8'h06, 8'hc0, 8'h80, 1'b0);
        dma(DMA_NONE, 8'h05, 8'h20, 8'h20, 1'b1);
        dack(8'hdf, 1'b1, 1'b1);
        dma(DMA_NONE, 8'h01, 8'h02, 8'h02, 1'b1);
    endtask

    task automatic t_reset();
        cfg(IX_ACTIVATE, 8'h00);
        inp(1'b1, 1'b1, 1'b1);
        rd(16'h0530, 8'h00, 1'b1, 1'b0);
        chk("isa_irq", 16'h0000, isa_irq);
        chk("isa_drq", 16'h0000, isa_drq);
        cfg(IX_ACTIVATE, 8'h01);
        rd(16'h0530, 8'h00, 1'b1, 1'b1);
        chk("isa_irq", 16'h0400, isa_irq);
        cfg(IX_CFG_CTL, 8'h05);
        idx(IX_CSN);
        rd(16'h0203, CSN_RESET, 1'b0, 1'b0);
        rd(16'h0530, 8'h00, 1'b1, 1'b0);
        chk("isa_irq", 16'h0000, isa_irq);
        rst = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(16'h0530, 8'h00, 1'b1, 1'b0);
        chk("isa_irq", 16'h0000, isa_irq);
        chk("isa_drq", 16'h0000, isa_drq);
    endtask

    initial begin
        repeat (30000) @(posedge ref_clk);
        n_fail++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        strap = 1'b1;
        c_irq = 1'b0;
        p_drq = 1'b0;
        c_drq = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge ref_clk);
        t_key();
        strap = 1'b0;
        repeat (5) @(posedge ref_clk);
        t_rdport();
        t_codec();
        t_dma();
        t_reset();
        close_out();
    end
endmodule
